// [adc_input_select_decoder.sv]
// Input selection and self-check decoder for the converter's first register.
// How it works
// (R01) Bits 3 to 7 of the first register decide which inputs convert.
// (R02) Plain code 000xx picks one single-ended input by pick bits.
// (R03) Code 0010x converts first or second pair differentially.
// (R04) Scan code 10001 alternates first-pair plus and minus.
// (R05) Scan code 10010 cycles first plus, first minus, second plus.
// (R06) Scan code 10011 cycles all four single-ended inputs in order.
// (R07) Scan code 10101 alternates first plus and second pair differential.
// (R08) Scan code 10110 cycles first plus, first minus, second differential.
// (R09) Scan code 11001 alternates first and second differential pairs.
// (R10) Without scan, the low pair-count bit picks differential mode.
// (R11) Autoscan only when the scan bit is set and several channels run.
// (R12) Bits 8 and 9 choose normal inputs or one of three references.
// (R13) Host writes value on bits 0-9, register select on bits 10-11.
// (R14) Host writes no reserved selection code; their result is undefined.
// (R15) Each scan step yields one result, in listed channel order.
`timescale 1ns/1ps
`include "adc_sel_cfg.svh"
module adc_input_select_decoder
  import adc_sel_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  input  wire logic                   i_ce,
  input  wire logic                   i_wr_stb,
  input  wire logic [`CFG_DATA_W-1:0] i_wr_data,
  input  wire logic                   i_conv_done,
  output logic      [`CFG_REG_W-1:0]  o_sel_cfg,
  output chan_t                       o_chan,
  output source_t                     o_source,
  output logic      [2:0]             o_seq_len,
  output logic      [1:0]             o_step,
  output logic                        o_scan_active,
  output logic                        o_code_reserved
);

  // Whole state of the block.
  typedef struct packed {
    logic [`CFG_REG_W-1:0] cr0;
    logic [1:0]            step;
  } state_t;

  state_t st_q;
  state_t st_d;

  // Channel sequence for a five-bit selection code.
  function automatic chan_t seq_chan(input logic [4:0] code,
                                     input logic [1:0] step);
    chan_t c;
    c = CH_FIRST_PLUS;
    case (code)
      5'h00: c = CH_FIRST_PLUS;                                    // [R02]
      5'h01: c = CH_FIRST_MINUS;                                   // [R02]
      5'h02: c = CH_SECOND_PLUS;                                   // [R02]
      5'h03: c = CH_SECOND_MINUS;                                  // [R02]
      5'h04: c = CH_FIRST_DIFF;                                // [R03] [R10]
      5'h05: c = CH_SECOND_DIFF;                               // [R03] [R10]
      5'h11: c = step[0] ? CH_FIRST_MINUS : CH_FIRST_PLUS;         // [R04]
      5'h12: c = chan_t'(step);                                    // [R05]
      5'h13: c = chan_t'(step);                                    // [R06]
      5'h15: c = step[0] ? CH_SECOND_DIFF : CH_FIRST_PLUS;         // [R07]
      5'h16: c = (step == 2'h2) ? CH_SECOND_DIFF : chan_t'(step);  // [R08]
      5'h19: c = step[0] ? CH_SECOND_DIFF : CH_FIRST_DIFF;         // [R09]
      default: c = CH_FIRST_PLUS;
    endcase
    return c;
  endfunction : seq_chan

  // Number of steps in the sequence; zero marks a reserved code.
  function automatic logic [2:0] seq_len(input logic [4:0] code);
    logic [2:0] n;
    n = 3'h0;
    case (code)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05: n = 3'h1;
      5'h11, 5'h15, 5'h19: n = 3'h2;                              // [R11]
      5'h12, 5'h16: n = 3'h3;                                     // [R11]
      5'h13: n = 3'h4;                                            // [R11]
      default: n = 3'h0;
    endcase
    return n;
  endfunction : seq_len

  logic [4:0] code;
  logic [2:0] len;
  logic       cr0_write;

  // Selection field and register decode of a host write.
  assign code = st_q.cr0[`CFG_SCAN_BIT:`CFG_PICK_LSB];             // [R01]
  assign len  = seq_len(code);
  assign cr0_write = i_wr_stb &&
    (i_wr_data[`CFG_DATA_W-1:`CFG_REGSEL_LSB] == `CFG_REGSEL_CR0); // [R13]

  // Next state: load the register, advance the step per conversion.
  always_comb
  begin
    st_d = st_q;
    if (i_ce)
    begin
      if (cr0_write)
      begin
        st_d.cr0  = i_wr_data[`CFG_REG_W-1:0];
        st_d.step = 2'h0;
      end
      else if (i_conv_done)
      begin
        if (len < 3'h2 || {1'b0, st_q.step} == len - 3'h1)
          st_d.step = 2'h0;                                        // [R15]
        else
          st_d.step = st_q.step + 2'h1;                            // [R15]
      end
    end
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_q.cr0  <= `CFG_CR0_RESET;
      st_q.step <= 2'h0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs decoded from registered state.
  assign o_sel_cfg       = st_q.cr0;
  assign o_chan          = seq_chan(code, st_q.step);
  assign o_source        =
    source_t'(st_q.cr0[`CFG_SELF_LSB+1:`CFG_SELF_LSB]);            // [R12]
  assign o_seq_len       = len;
  assign o_step          = st_q.step;
  assign o_scan_active   = st_q.cr0[`CFG_SCAN_BIT] && (len > 3'h1); // [R11]
  assign o_code_reserved = (len == 3'h0);                          // [R14]

  // All checks below run on the block clock and pause during reset.
  default clocking chk_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // Named sequence: an in-sequence conversion completes.
  sequence conv_step;
    i_ce && !cr0_write && i_conv_done;
  endsequence

  // Named sequence: a host write reaches the first register.
  sequence cfg_load;
    i_ce && cr0_write;
  endsequence

  // Named sequence: the clock enable is low, so nothing may move.
  sequence frozen_cycle;
    !i_ce;
  endsequence

  // A write lands in full and restarts the sequence at its first step.
  AST_WRITE_LOADS: assert property ( // [R13]
    cfg_load |=> o_sel_cfg == $past(i_wr_data[`CFG_REG_W-1:0])
      && o_step == 2'h0)
    else $error("First register write not loaded.");

  // The last step of a sequence is followed by the first one.
  AST_WRAP_AT_END: assert property ( // [R15]
    conv_step and ({1'b0, o_step} == o_seq_len - 3'h1) |=> o_step == 2'h0)
    else $error("Scan step did not wrap.");

  // Any earlier step moves on by one per finished conversion.
  AST_STEP_ADVANCES: assert property ( // [R15]
    conv_step and ({1'b0, o_step} < o_seq_len - 3'h1) and (o_seq_len > 3'h1)
      |=> o_step == $past(o_step) + 2'h1)
    else $error("Scan step did not advance.");

  // The step index never leaves the sequence.
  AST_STEP_BOUND: assert property ( // [R11]
    o_seq_len != 3'h0 |-> {1'b0, o_step} < o_seq_len)
    else $error("Scan step beyond sequence.");

  // Without the scan bit there is no autoscan and the step stays put.
  AST_SINGLE_FIXED: assert property ( // [R11]
    !o_sel_cfg[`CFG_SCAN_BIT] |-> !o_scan_active && o_step == 2'h0)
    else $error("Autoscan without scan bit.");

  // A differential single pick follows the low pick bit.
  AST_DIFF_SINGLE: assert property ( // [R10]
    o_sel_cfg[`CFG_SCAN_BIT:`CFG_PCLO_BIT] == 3'h1 && !o_code_reserved
      |-> o_chan == (o_sel_cfg[`CFG_PICK_LSB] ? CH_SECOND_DIFF
                                               : CH_FIRST_DIFF))
    else $error("Differential single pick wrong.");

  // Four single-ended inputs come in their listed order.
  AST_FOUR_ORDER: assert property ( // [R06]
    code == 5'h13 |-> o_chan == (o_step == 2'h0 ? CH_FIRST_PLUS
                               : o_step == 2'h1 ? CH_FIRST_MINUS
                               : o_step == 2'h2 ? CH_SECOND_PLUS
                                                : CH_SECOND_MINUS))
    else $error("Four-input scan order wrong.");

  // Three single-ended inputs come in their listed order.
  AST_THREE_ORDER: assert property ( // [R05]
    code == 5'h12 |-> o_chan == (o_step == 2'h0 ? CH_FIRST_PLUS
                               : o_step == 2'h1 ? CH_FIRST_MINUS
                                                : CH_SECOND_PLUS))
    else $error("Three-input scan order wrong.");

  // Two single-ended inputs, then the second pair differentially.
  AST_MIXED_ORDER: assert property ( // [R08]
    code == 5'h16 |-> o_chan == (o_step == 2'h0 ? CH_FIRST_PLUS
                               : o_step == 2'h1 ? CH_FIRST_MINUS
                                                : CH_SECOND_DIFF))
    else $error("Mixed three-step scan order wrong.");

  // The first pair is followed by the second pair.
  AST_PAIR_ALT: assert property ( // [R09]
    (code == 5'h19 && o_step == 2'h0) and conv_step
      |=> o_chan == CH_SECOND_DIFF)
    else $error("Pair scan did not alternate.");

  // After the differential pair the scan returns to first-pair plus.
  AST_MIXED_ALT: assert property ( // [R07]
    (code == 5'h15 && o_step == 2'h1) and conv_step
      |=> o_chan == CH_FIRST_PLUS)
    else $error("Mixed pair scan did not return.");

  // The self-check field of a write picks the converted source.
  AST_SELFCHECK: assert property ( // [R12]
    cfg_load |=> o_source ==
      source_t'($past(i_wr_data[`CFG_SELF_LSB+1:`CFG_SELF_LSB])))
    else $error("Self-check source mismatch.");

  // A low clock enable holds the register and the step.
  AST_CE_FREEZES: assert property ( // [R01]
    frozen_cycle |=> $stable(o_sel_cfg) && $stable(o_step))
    else $error("State moved while clock enable was low.");

  // A reserved code runs no scan and rests on the first step.
  AST_RESERVED_IDLE: assert property ( // [R11]
    o_code_reserved |-> o_step == 2'h0 && !o_scan_active
      && o_chan == CH_FIRST_PLUS)
    else $error("Reserved code left its resting state.");

endmodule : adc_input_select_decoder

// [adc_sel_cfg.svh]
// Constants for the input selection decoder: field positions and reset values.
`ifndef ADC_SEL_CFG_SVH
`define ADC_SEL_CFG_SVH
`define CFG_DATA_W        12
`define CFG_REG_W         10
`define CFG_REGSEL_LSB    10
`define CFG_REGSEL_CR0    2'h0
`define CFG_REGSEL_CR1    2'h1
`define CFG_PICK_LSB      3
`define CFG_PCLO_BIT      5
`define CFG_PCHI_BIT      6
`define CFG_SCAN_BIT      7
`define CFG_SELF_LSB      8
`define CFG_CR0_RESET     10'h020
`define CFG_CR1_RESET     10'h030
`endif

// [adc_sel_pkg.sv]
// Types shared by the input selection decoder.
package adc_sel_pkg;
  // One converted channel: a single input or a differential pair.
  typedef enum logic [2:0] {
    CH_FIRST_PLUS,
    CH_FIRST_MINUS,
    CH_SECOND_PLUS,
    CH_SECOND_MINUS,
    CH_FIRST_DIFF,
    CH_SECOND_DIFF
  } chan_t;
  // Source actually fed to the converter.
  typedef enum logic [1:0] {
    SRC_INPUTS,
    SRC_UPPER_REF,
    SRC_MID_REF,
    SRC_LOWER_REF
  } source_t;
endpackage : adc_sel_pkg

// [adc_host_model.sv]
// Host processor model that writes registers and reports conversions.
`timescale 1ns/1ps
`include "adc_sel_cfg.svh"
module adc_host_model
(
  input  wire logic                   i_clk,
  output logic                        o_wr_stb,
  output logic      [`CFG_DATA_W-1:0] o_wr_data,
  output logic                        o_conv_done
);
  // Lines start idle so that no request is made before reset ends.
  initial
  begin
    o_wr_stb = 1'b0;
    o_wr_data = 12'h000;
    o_conv_done = 1'b0;
  end
  // Sends one word: select above, value below; then shows the inverse.
  task automatic write_word(input logic [1:0] sel, input logic [9:0] val);
    @(posedge i_clk);
    #1;
    o_wr_stb = 1'b1;
    o_wr_data = {sel, val};
    @(posedge i_clk);
    #1;
    o_wr_stb = 1'b0;
    o_wr_data = ~{sel, val};
  endtask : write_word
  // Raises a write and a conversion report on the same edge.
  task automatic write_with_done(input logic [1:0] sel,
                                 input logic [9:0] val);
    @(posedge i_clk);
    #1;
    o_wr_stb = 1'b1;
    o_wr_data = {sel, val};
    o_conv_done = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr_stb = 1'b0;
    o_wr_data = ~{sel, val};
    o_conv_done = 1'b0;
  endtask : write_with_done
  // Reports one finished conversion as a one-cycle pulse.
  task automatic pulse_done();
    @(posedge i_clk);
    #1;
    o_conv_done = 1'b1;
    @(posedge i_clk);
    #1;
    o_conv_done = 1'b0;
  endtask : pulse_done
endmodule : adc_host_model

// [adc_input_select_decoder_tb.sv]
// Self-checking bench for the input selection decoder.
`timescale 1ns/1ps
`include "adc_sel_cfg.svh"
module adc_input_select_decoder_tb
  import adc_sel_pkg::*;
;
  logic clk, resetn, ce, stb, done, act, rsv;
  logic [11:0] wdata;
  logic [9:0] cfg;
  chan_t chan;
  source_t src;
  logic [2:0] len;
  logic [1:0] step;
  int num_errors = 0;
  int check_count = 0;
  logic [4:0] sc_code [6] = '{5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h19};
  logic [2:0] sc_len [6] = '{3'h2, 3'h3, 3'h4, 3'h2, 3'h3, 3'h2};
  logic [11:0] sc_seq [6] = '{12'h008, 12'h088, 12'h688, 12'h028,
                              12'h148, 12'h02c};
  adc_host_model host (.i_clk(clk), .o_wr_stb(stb), .o_wr_data(wdata),
                       .o_conv_done(done));
  adc_input_select_decoder uut (.i_clk(clk), .i_resetn(resetn), .i_ce(ce),
    .i_wr_stb(stb), .i_wr_data(wdata), .i_conv_done(done), .o_sel_cfg(cfg),
    .o_chan(chan), .o_source(src), .o_seq_len(len), .o_step(step),
    .o_scan_active(act), .o_code_reserved(rsv));
  // Compares a seen value with the expected one and counts both outcomes.
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  // Plain and differential single picks; a conversion leaves them alone.
  task automatic test_single();
    for (int i = 0; i < 6; i++)
    begin
      host.write_word(2'h0, 10'(i << 3));
      check(10'(chan), 10'(i));
      check({act, rsv, 5'h0, len}, 10'h001);
      host.pulse_done();
      check({5'h0, step, chan}, 10'(i));
    end
    $display("test single done");
  endtask : test_single
  // Every autoscan code, stepped past its wrap; writes restart at step 0.
  task automatic test_scan();
    logic [2:0] exp_chan;
    for (int k = 0; k < 6; k++)
    begin
      host.write_word(2'h0, {2'h0, sc_code[k], 3'h0});
      check({act, 6'h0, len}, {7'h40, sc_len[k]});
      for (int s = 0; s <= sc_len[k]; s++)
      begin
        exp_chan = sc_seq[k][3*(s%sc_len[k])+:3];
        check(10'(chan), 10'(exp_chan));
        check(10'(step), 10'(s % sc_len[k]));
        host.pulse_done();
      end
    end
    $display("test scan done");
  endtask : test_scan
  // Self-check sources, then ignored selects, a frozen clock enable, codes.
  task automatic test_misc();
    for (int t = 0; t < 4; t++)
    begin
      host.write_word(2'h0, {2'(t), 8'h20});
      check(10'(src), 10'(t));
    end
    host.write_word(2'h1, 10'h3ff);
    check(cfg, 10'h320);
    ce = 1'b0;
    host.write_word(2'h0, 10'h098);
    check(cfg, 10'h320);
    ce = 1'b1;
    host.write_word(2'h0, 10'h0b8);
    check({rsv, 6'h0, len}, 10'h200);
    host.pulse_done();
    check({5'h0, step, chan}, 10'h000);
    host.write_word(2'h0, 10'h098);
    host.pulse_done();
    check(10'(step), 10'h001);
    ce = 1'b0;
    host.pulse_done();
    check(10'(step), 10'h001);
    ce = 1'b1;
    host.write_with_done(2'h0, 10'h099);
    check({step, cfg[7:0]}, 10'h099);
    $display("test misc done");
  endtask : test_misc
  // Clock of 4 ns period.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Watchdog that cuts a hang short.
  initial
  begin
    #100000;
    num_errors++;
    report_and_stop();
  end
  // Reset for three cycles, then each scenario in turn.
  initial
  begin
    resetn = 1'b0;
    ce = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    check({cfg[9:3], chan}, 10'h024);
    check({2'(src), step, 3'h0, len}, 10'h001);
    test_single();
    test_scan();
    test_misc();
    report_and_stop();
  end
endmodule : adc_input_select_decoder_tb
